// *** src/stack_unit_pkg.sv ***
// package for the stack and parallel or-store execution unit.
// assumes a 32-bit classic wishbone slave port and a single 100 MHz clock.
package stack_unit_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CMD0     = 8'h00;
   localparam logic [7:0] OFS_CMD1     = 8'h04;
   localparam logic [7:0] OFS_CTRL     = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0c;
   localparam logic [7:0] OFS_REG_SEL  = 8'h10;
   localparam logic [7:0] OFS_REG_LOW  = 8'h14;
   localparam logic [7:0] OFS_REG_EXP  = 8'h18;
   localparam logic [7:0] OFS_MEM_SEL  = 8'h1c;
   localparam logic [7:0] OFS_MEM_DATA = 8'h20;
   // ==========================================================
   // register file layout
   localparam logic [4:0] NUM_REGS  = 5'h1c;
   localparam logic [4:0] NUM_EXT   = 5'h08;
   localparam logic [4:0] REG_AUX0  = 5'h08;
   localparam logic [4:0] REG_IDX_A = 5'h11;
   localparam logic [4:0] REG_IDX_B = 5'h12;
   localparam logic [4:0] REG_SP    = 5'h14;
   localparam logic [7:0] FLOAT_ZERO_EXP = 8'h80;
   localparam logic [7:0] LOW_FILL       = 8'h00;
   // ==========================================================
   // command word fields
   localparam int F_OP    = 0;
   localparam int F_DST   = 4;
   localparam int F_SRC1  = 12;
   localparam int F_SRC3  = 20;
   localparam int F_S2REG = 0;
   localparam int F_S2ISR = 5;
   localparam int F_S2BAS = 8;
   localparam int F_S2MOD = 12;
   localparam int F_D2BAS = 16;
   localparam int F_D2MOD = 20;
   // ==========================================================
   // control, status and flag bits
   localparam int CTRL_SAT    = 0;
   localparam int CTRL_REGSRC = 1;
   localparam int FL_C   = 0;
   localparam int FL_V   = 1;
   localparam int FL_Z   = 2;
   localparam int FL_N   = 3;
   localparam int FL_UF  = 4;
   localparam int FL_LV  = 5;
   localparam int FL_LUF = 6;
   localparam int ST_ILLEGAL = 8;
   localparam int ST_BUSY    = 9;
   typedef enum logic [1:0] {
      OP_OR_STORE, OP_POP_INT, OP_POP_FLOAT, OP_PUSH_INT
   } op_e;
   typedef enum logic [1:0] {
      IND_DISP0, IND_DISP1, IND_IDX_A, IND_IDX_B
   } ind_e;
   typedef enum logic [0:0] {S_IDLE = 1'b0, S_EXEC = 1'b1} state_e;
endpackage : stack_unit_pkg

// *** src/stack_or_store_unit.sv ***
// execution unit for the parallel or-store and the stack pop and push ops.
// assumes a classic wishbone master on clk_i and that ce_i comes from the
// same clock domain; the register file and data memory live in this block.
`timescale 1ns/1ns
`default_nettype none
module stack_or_store_unit #(
   parameter int MEM_DEPTH    = 64,
   parameter bit REG_SRC2_DEF = 1'b1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o
);
   localparam int MEM_AW = $clog2(MEM_DEPTH);

   // ==========================================================
   // state
   logic [31:0]        cmd0;
   logic [31:0]        cmd1;
   logic               sat_mode;
   logic               reg_src2_en;
   logic [6:0]         flags;
   logic               illegal;
   logic [4:0]         reg_sel;
   logic [MEM_AW-1:0]  mem_sel;
   logic [31:0]        low_q [stack_unit_pkg::NUM_REGS];
   logic [7:0]         exp_q [stack_unit_pkg::NUM_EXT];
   logic [31:0]        mem_q [MEM_DEPTH];
   stack_unit_pkg::state_e state;

   // ==========================================================
   // helpers
   // byte-lane merge for wishbone writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // indirect address: aux register plus displacement 0, 1 or an index register
   function automatic logic [MEM_AW-1:0] ind_addr(input logic [31:0] base, input logic [1:0] mode,
                                                 input logic [31:0] ia, input logic [31:0] ib);
      logic [31:0] a;
      case (stack_unit_pkg::ind_e'(mode))
         stack_unit_pkg::IND_DISP0: a = base;
         stack_unit_pkg::IND_DISP1: a = base + 32'h1;
         stack_unit_pkg::IND_IDX_A: a = base + ia;
         default:                   a = base + ib;
      endcase
      return a[MEM_AW-1:0];
   endfunction : ind_addr

   // ==========================================================
   // command decode
   wire stack_unit_pkg::op_e op = stack_unit_pkg::op_e'(cmd0[stack_unit_pkg::F_OP +: 2]);
   wire [4:0] dst     = cmd0[stack_unit_pkg::F_DST +: 5];
   wire [4:0] src1    = cmd0[stack_unit_pkg::F_SRC1 +: 5];
   wire [4:0] src3    = cmd0[stack_unit_pkg::F_SRC3 +: 5];
   wire [4:0] s2_reg  = cmd1[stack_unit_pkg::F_S2REG +: 5];
   wire       s2_isr  = cmd1[stack_unit_pkg::F_S2ISR];
   wire [4:0] s2_aux  = stack_unit_pkg::REG_AUX0 | {2'b00, cmd1[stack_unit_pkg::F_S2BAS +: 3]};
   wire [4:0] d2_aux  = stack_unit_pkg::REG_AUX0 | {2'b00, cmd1[stack_unit_pkg::F_D2BAS +: 3]};
   wire [1:0] s2_mode = cmd1[stack_unit_pkg::F_S2MOD +: 2];
   wire [1:0] d2_mode = cmd1[stack_unit_pkg::F_D2MOD +: 2];

   // operand fetch: every read comes from the current, not yet updated, state
   wire [31:0]       idx_a   = low_q[stack_unit_pkg::REG_IDX_A];
   wire [31:0]       idx_b   = low_q[stack_unit_pkg::REG_IDX_B];
   wire [MEM_AW-1:0] s2_addr = ind_addr(low_q[s2_aux], s2_mode, idx_a, idx_b);
   wire [MEM_AW-1:0] st_addr = ind_addr(low_q[d2_aux], d2_mode, idx_a, idx_b);
   wire [31:0]       s2_val  = s2_isr ? low_q[s2_reg] : mem_q[s2_addr];
   wire [31:0]       or_res  = low_q[src1] | s2_val;
   wire [31:0]       st_val  = low_q[src3];
   wire [31:0]       sp      = low_q[stack_unit_pkg::REG_SP];
   wire [31:0]       sp_inc  = sp + 32'h1;
   wire [31:0]       sp_dec  = sp - 32'h1;
   wire [31:0]       pop_w   = mem_q[sp[MEM_AW-1:0]];
   wire [31:0]       push_w  = low_q[dst];

   // legality: operand classes per op; an illegal command is dropped whole
   wire dst_ok  = dst < stack_unit_pkg::NUM_REGS;
   wire dst_ext = dst < stack_unit_pkg::NUM_EXT;
   wire s2_ok   = !s2_isr || (reg_src2_en && s2_reg < stack_unit_pkg::NUM_REGS);
   wire or_ok   = dst_ext && src1 < stack_unit_pkg::NUM_EXT
                  && src3 < stack_unit_pkg::NUM_EXT && s2_ok;
   wire legal   = (op == stack_unit_pkg::OP_OR_STORE)  ? or_ok :
                  (op == stack_unit_pkg::OP_POP_FLOAT) ? dst_ext : dst_ok;
   wire in_exec = (state == stack_unit_pkg::S_EXEC) && ce_i;
   wire ex_fire = in_exec && legal;
   wire is_or   = op == stack_unit_pkg::OP_OR_STORE;
   wire is_float_pop = op == stack_unit_pkg::OP_POP_FLOAT;
   wire is_push = op == stack_unit_pkg::OP_PUSH_INT;

   // flag update; sat_mode is deliberately absent from every result path
   wire [31:0] res      = is_or ? or_res : pop_w;
   wire        res_zero = is_float_pop ? (pop_w[31:24] == stack_unit_pkg::FLOAT_ZERO_EXP)
                                  : (res == 32'h0);
   wire        res_neg  = is_float_pop ? pop_w[23] : res[31];
   wire        flag_upd = ex_fire && dst_ext && !is_push;
   logic [6:0] next_flags;
   always_comb begin
      next_flags = flags;
      if (flag_upd) begin
         next_flags[stack_unit_pkg::FL_N]  = res_neg;
         next_flags[stack_unit_pkg::FL_Z]  = res_zero;
         next_flags[stack_unit_pkg::FL_UF] = 1'b0;
         next_flags[stack_unit_pkg::FL_V]  = 1'b0;
      end
   end

   // ==========================================================
   // wishbone slave: ack one cycle after the request, commit on the ack edge
   wire bus_req = wb_cyc_i && wb_stb_i;
   wire bus_wr  = bus_req && wb_we_i && wb_ack_o;
   wire wr_cmd0 = bus_wr && wb_adr_i == stack_unit_pkg::OFS_CMD0;
   wire wr_cmd1 = bus_wr && wb_adr_i == stack_unit_pkg::OFS_CMD1;
   wire wr_ctrl = bus_wr && wb_adr_i == stack_unit_pkg::OFS_CTRL;
   wire wr_stat = bus_wr && wb_adr_i == stack_unit_pkg::OFS_STATUS;
   wire wr_rsel = bus_wr && wb_adr_i == stack_unit_pkg::OFS_REG_SEL;
   wire wr_rlow = bus_wr && wb_adr_i == stack_unit_pkg::OFS_REG_LOW && reg_sel < stack_unit_pkg::NUM_REGS;
   wire wr_rexp = bus_wr && wb_adr_i == stack_unit_pkg::OFS_REG_EXP && reg_sel < stack_unit_pkg::NUM_EXT;
   wire wr_msel = bus_wr && wb_adr_i == stack_unit_pkg::OFS_MEM_SEL;
   wire wr_mdat = bus_wr && wb_adr_i == stack_unit_pkg::OFS_MEM_DATA;
   wire [31:0] ctrl_rd = {30'h0, reg_src2_en, sat_mode};
   wire [31:0] stat_rd = {22'h0, state == stack_unit_pkg::S_EXEC, illegal, 1'b0, flags};
   wire [31:0] rlow_rd = (reg_sel < stack_unit_pkg::NUM_REGS) ? low_q[reg_sel] : 32'h0;
   wire [31:0] rexp_rd = (reg_sel < stack_unit_pkg::NUM_EXT) ? {24'h0, exp_q[reg_sel[2:0]]} : 32'h0;
   wire [31:0] rd_data =
      (wb_adr_i == stack_unit_pkg::OFS_CMD0)     ? cmd0 :
      (wb_adr_i == stack_unit_pkg::OFS_CMD1)     ? cmd1 :
      (wb_adr_i == stack_unit_pkg::OFS_CTRL)     ? ctrl_rd :
      (wb_adr_i == stack_unit_pkg::OFS_STATUS)   ? stat_rd :
      (wb_adr_i == stack_unit_pkg::OFS_REG_SEL)  ? {27'h0, reg_sel} :
      (wb_adr_i == stack_unit_pkg::OFS_REG_LOW)  ? rlow_rd :
      (wb_adr_i == stack_unit_pkg::OFS_REG_EXP)  ? rexp_rd :
      (wb_adr_i == stack_unit_pkg::OFS_MEM_SEL)  ? 32'(mem_sel) :
      (wb_adr_i == stack_unit_pkg::OFS_MEM_DATA) ? mem_q[mem_sel] : 32'h0;

   // bus handshake; unmapped addresses still ack and read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= rd_data;
      end
   end

   // control registers and sequencer; a new command clears the illegal flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd0        <= 32'h0;
         cmd1        <= 32'h0;
         sat_mode    <= 1'b0;
         reg_src2_en <= REG_SRC2_DEF;
         reg_sel     <= 5'h0;
         mem_sel     <= '0;
         illegal     <= 1'b0;
         state       <= stack_unit_pkg::S_IDLE;
      end else if (ce_i) begin
         if (wr_cmd0) cmd0 <= lane_merge(cmd0, wb_dat_i, wb_sel_i);
         if (wr_cmd1) cmd1 <= lane_merge(cmd1, wb_dat_i, wb_sel_i);
         if (wr_ctrl && wb_sel_i[0]) begin
            sat_mode    <= wb_dat_i[stack_unit_pkg::CTRL_SAT];
            reg_src2_en <= wb_dat_i[stack_unit_pkg::CTRL_REGSRC];
         end
         if (wr_rsel && wb_sel_i[0]) reg_sel <= wb_dat_i[4:0];
         if (wr_msel) mem_sel <= wb_dat_i[MEM_AW-1:0];
         illegal <= (in_exec && !legal) || (illegal && !wr_cmd0);
         case (state)
            stack_unit_pkg::S_IDLE: if (wr_cmd0) state <= stack_unit_pkg::S_EXEC;
            stack_unit_pkg::S_EXEC: state <= stack_unit_pkg::S_IDLE;
            default:                state <= stack_unit_pkg::S_IDLE;
         endcase
      end
   end

   // flags: written by software through status, else by execution
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 7'h0;
      end else if (ce_i) begin
         if (wr_stat && wb_sel_i[0]) flags <= wb_dat_i[6:0];
         else flags <= next_flags;
      end
   end

   // register file: one edge writes all results, so every read saw old values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < int'(stack_unit_pkg::NUM_REGS); i++) low_q[i] <= 32'h0;
         for (int i = 0; i < int'(stack_unit_pkg::NUM_EXT); i++) exp_q[i] <= 8'h0;
      end else if (ce_i) begin
         if (wr_rlow) low_q[reg_sel] <= lane_merge(low_q[reg_sel], wb_dat_i, wb_sel_i);
         if (wr_rexp && wb_sel_i[0]) exp_q[reg_sel[2:0]] <= wb_dat_i[7:0];
         if (ex_fire) begin
            case (op)
               stack_unit_pkg::OP_OR_STORE: low_q[dst] <= or_res;
               stack_unit_pkg::OP_POP_INT: begin
                  low_q[stack_unit_pkg::REG_SP] <= sp_dec;
                  low_q[dst] <= pop_w;
               end
               stack_unit_pkg::OP_POP_FLOAT: begin
                  low_q[stack_unit_pkg::REG_SP] <= sp_dec;
                  exp_q[dst[2:0]] <= pop_w[31:24];
                  low_q[dst] <= {pop_w[23:0], stack_unit_pkg::LOW_FILL};
               end
               default: low_q[stack_unit_pkg::REG_SP] <= sp_inc;
            endcase
         end
      end
   end

   // data memory; the or-source was fetched before this edge, so a shared
   // location yields the old word to the or and the new one to the store
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (wr_mdat) mem_q[mem_sel] <= lane_merge(mem_q[mem_sel], wb_dat_i, wb_sel_i);
         if (ex_fire && is_or) mem_q[st_addr] <= st_val;
         if (ex_fire && is_push) mem_q[sp_inc[MEM_AW-1:0]] <= push_w;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire fire_or   = ex_fire && is_or;
   wire fire_popi = ex_fire && op == stack_unit_pkg::OP_POP_INT;
   wire fire_push = ex_fire && is_push;
   sequence s_cmd_taken;
      ce_i && wr_cmd0 && state == stack_unit_pkg::S_IDLE;
   endsequence
   sequence s_exec_done;
      (ce_i && state == stack_unit_pkg::S_EXEC)
         ##1 state == stack_unit_pkg::S_IDLE;
   endsequence

   a_exec_one_cycle: assert property (s_cmd_taken |=> s_exec_done or !ce_i)
      else $error("execute did not finish in one cycle");
   a_or_result: assert property (fire_or |=> low_q[$past(dst)] == $past(or_res))
      else $error("or result not written");
   a_store_old: assert property (fire_or |=> mem_q[$past(st_addr)] == $past(st_val))
      else $error("store did not use the old register value");
   a_pop_sp_dec: assert property (fire_popi && dst != stack_unit_pkg::REG_SP
                                  |=> low_q[stack_unit_pkg::REG_SP] == $past(sp) - 32'h1)
      else $error("pop did not decrement the stack pointer");
   a_pop_exp_keep: assert property (fire_popi && dst_ext |=> exp_q[$past(dst[2:0])] == $past(exp_q[dst[2:0]]))
      else $error("integer pop changed an exponent");
   a_float_pop_fill: assert property (ex_fire && is_float_pop |=> low_q[$past(dst)][7:0] == stack_unit_pkg::LOW_FILL)
      else $error("float pop did not zero-fill");
   a_push_store: assert property (fire_push |=> mem_q[$past(sp_inc[MEM_AW-1:0])] == $past(push_w)
                                  && low_q[stack_unit_pkg::REG_SP] == $past(sp_inc))
      else $error("push did not preincrement and store");
   a_push_flags: assert property (fire_push && !wr_stat |=> flags == $past(flags))
      else $error("push changed flags");
   a_flag_hold: assert property (ex_fire && !dst_ext && !wr_stat |=> $stable(flags))
      else $error("flags changed for a non-extended destination");
   a_zero_flag: assert property (flag_upd && !wr_stat |=> flags[stack_unit_pkg::FL_Z] == $past(res_zero)
                                 && flags[stack_unit_pkg::FL_UF] == 1'b0)
      else $error("zero or underflow flag wrong");
   a_latched_keep: assert property (flag_upd && !wr_stat |=> flags[6:5] == $past(flags[6:5])
                                    && flags[stack_unit_pkg::FL_C] == $past(flags[stack_unit_pkg::FL_C]))
      else $error("latched or carry flag changed");
   // a refused command must leave the stack pointer and the flags alone
   a_illegal_idle: assert property (in_exec && !legal && !wr_stat
                                    |=> $stable(flags) && low_q[stack_unit_pkg::REG_SP] == $past(sp))
      else $error("refused command changed state");
   // shared location: the or must see the word as it stood before the store
   a_shared_read: assert property (fire_or && !s2_isr && s2_addr == st_addr
                                   |=> low_q[$past(dst)] == $past(low_q[src1] | mem_q[st_addr]))
      else $error("shared location read after the store");
   // float pop: exponent takes the top byte of the stack word
   a_float_pop_exp: assert property (ex_fire && is_float_pop |=> exp_q[$past(dst[2:0])] == $past(pop_w[31:24]))
      else $error("float pop exponent wrong");
   // integer pop: sign of the word to negative, overflow cleared
   a_pop_neg: assert property (fire_popi && dst_ext && !wr_stat
                               |=> flags[stack_unit_pkg::FL_N] == $past(pop_w[31])
                                   && flags[stack_unit_pkg::FL_V] == 1'b0)
      else $error("integer pop flags wrong");
   // the or drives the negative flag from the top bit of its result
   a_or_neg: assert property (fire_or && !wr_stat
                              |=> flags[stack_unit_pkg::FL_N] == $past(low_q[src1][31] | s2_val[31]))
      else $error("or negative flag wrong");
endmodule : stack_or_store_unit
`default_nettype wire

// *** verification/wb_host.sv ***
// classic wishbone master model that stands in for the cpu side of the unit.
// assumes one clock and a slave that answers each request with an ack pulse.
`timescale 1ns/1ns
`default_nettype none
module wb_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   output var  logic        cyc_o,
   output var  logic        stb_o,
   output var  logic        we_o,
   output var  logic [7:0]  adr_o,
   output var  logic [3:0]  sel_o,
   output var  logic [31:0] dat_o
);
   // ==========================================================
   // idle bus from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'hf;
      dat_o = 32'h0;
   end
   // one single cycle: request held until ack is seen at an edge, then an
   // idle cycle so two strobes never merge into one request
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      @(posedge clk_i);
   endtask : xfer
endmodule : wb_host
`default_nettype wire

// *** verification/stack_and_parallel_or_store_tb.sv ***
// self-checking bench for the stack and parallel or-store unit.
// assumes the unit's register map and a 100 MHz clock; reads are scored in order.
`timescale 1ns/1ns
`default_nettype none
module stack_and_parallel_or_store_tb;
   typedef struct {string nm; logic [31:0] v;} exp_s;
   logic        clk_i, rst_i, ce_i, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, s, w, a, m, b, st;
   exp_s        q[$];
   exp_s        e;
   int          bad_count, checks;
   // ==========================================================
   // clock, host model and unit under test
   always #5 clk_i = ~clk_i;
   wb_host i_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
                   .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   stack_or_store_unit #(.MEM_DEPTH(64), .REG_SRC2_DEF(1'b1)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
   // ==========================================================
   // bus helpers; a read only notes its expectation, the monitor compares
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      i_host.xfer(1'b1, ad, d);
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [31:0] v, input string nm);
      q.push_back('{nm, v});
      i_host.xfer(1'b0, ad, 32'h0);
   endtask : rd
   task automatic setr(input logic [4:0] n, input logic [31:0] lo, input logic [7:0] ex);
      wr(stack_unit_pkg::OFS_REG_SEL, {27'h0, n});
      wr(stack_unit_pkg::OFS_REG_LOW, lo);
      if (n < 5'h08) wr(stack_unit_pkg::OFS_REG_EXP, {24'h0, ex});
   endtask : setr
   task automatic chkr(input logic [4:0] n, input logic [31:0] lo, input logic [7:0] ex, input string nm);
      wr(stack_unit_pkg::OFS_REG_SEL, {27'h0, n});
      rd(stack_unit_pkg::OFS_REG_LOW, lo, nm);
      if (n < 5'h08) rd(stack_unit_pkg::OFS_REG_EXP, {24'h0, ex}, nm);
   endtask : chkr
   task automatic mem(input logic [31:0] i, input logic [31:0] d, input logic chk, input string nm);
      wr(stack_unit_pkg::OFS_MEM_SEL, i);
      if (chk) rd(stack_unit_pkg::OFS_MEM_DATA, d, nm);
      else wr(stack_unit_pkg::OFS_MEM_DATA, d);
   endtask : mem
   task automatic run(input logic [31:0] c1, input logic [31:0] c0);
      wr(stack_unit_pkg::OFS_CMD1, c1);
      wr(stack_unit_pkg::OFS_CMD0, c0);
   endtask : run
   task automatic flags(input logic [31:0] v, input string nm);
      rd(stack_unit_pkg::OFS_STATUS, v, nm);
   endtask : flags
   // ==========================================================
   // monitor: every read answer is matched against the oldest note
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
         e = q.pop_front();
         checks++;
         if (rdat !== e.v) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", e.nm, e.v, rdat);
         end
      end
   end
   // single closing point for normal end and watchdog
   task automatic results();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   // watchdog sized well above the hundred or so accesses of the sequence
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      results();
   end
   // ==========================================================
   // main sequence
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      ce_i  = 1'b1;
      s = $urandom(32'h8c24);
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(stack_unit_pkg::OFS_CTRL, 32'h2, "ctrl_reset");
      flags(32'h0, "status_reset");
      rd(8'hfc, 32'h0, "unmapped");
      // push: pointer moves up first, low word lands on the new top, flags kept
      s = $urandom() & 32'h7f;
      w = $urandom();
      wr(stack_unit_pkg::OFS_STATUS, s);
      setr(5'd20, 32'h5, 8'h0);
      setr(5'd3, w, 8'h55);
      run(32'h0, 32'h33);
      chkr(5'd20, 32'h6, 8'h0, "sp_push");
      mem(32'h6, w, 1'b1, "stack_top");
      flags(s, "flags_push");
      // integer pop of a negative word into r2, exponent must survive
      w = $urandom() | 32'h8000_0000;
      mem(32'h6, w, 1'b0, "");
      setr(5'd2, 32'h0, 8'h12);
      run(32'h0, 32'h21);
      chkr(5'd2, w, 8'h12, "pop_int");
      st = (s & 32'h61) | 32'h8;
      flags(st, "flags_pop_int");
      // zero popped into r25: any of the 28 registers accepted, no flag change
      setr(5'd25, $urandom(), 8'h0);
      mem(32'h5, 32'h0, 1'b0, "");
      run(32'h0, 32'h191);
      chkr(5'd25, 32'h0, 8'h0, "pop_r25");
      chkr(5'd20, 32'h4, 8'h0, "sp_pop");
      flags(st, "flags_non_ext");
      // float pop: word goes high, eight low mantissa bits zero
      w = $urandom();
      mem(32'h4, w, 1'b0, "");
      run(32'h0, 32'h42);
      chkr(5'd4, {w[23:0], 8'h0}, w[31:24], "pop_float");
      st = (st & 32'h61) | {28'h0, w[23], w[31:24] == 8'h80, 2'b00};
      flags(st, "flags_pop_float");
      // or-store sharing one location; store reads r1 before the or writes it
      wr(stack_unit_pkg::OFS_CTRL, 32'h3);
      a = $urandom();
      m = $urandom();
      setr(5'd8, 32'ha, 8'h0);
      setr(5'd1, a, 8'h33);
      mem(32'hb, m, 1'b0, "");
      run(32'h0010_1000, 32'h0010_1010);
      chkr(5'd1, a | m, 8'h33, "or_result");
      mem(32'hb, a, 1'b1, "store_old");
      b = a | m;
      st = (st & 32'h61) | {28'h0, b[31], b == 32'h0, 2'b00};
      flags(st, "flags_or");
      // register second source and indexed store, zero result
      b = $urandom();
      setr(5'd21, 32'h0, 8'h0);
      setr(5'd6, 32'h0, 8'h0);
      setr(5'd7, b, 8'h0);
      setr(5'd9, 32'd20, 8'h0);
      setr(5'd18, 32'h3, 8'h0);
      run(32'h0031_0035, 32'h0070_6060);
      chkr(5'd6, 32'h0, 8'h0, "or_zero");
      mem(32'd23, b, 1'b1, "store_indexed");
      st = (st & 32'h61) | 32'h4;
      flags(st, "flags_zero");
      // memory source through index_register_a, shared with the store
      m = $urandom();
      setr(5'd17, 32'h2, 8'h0);
      setr(5'd5, 32'h0, 8'h0);
      mem(32'hc, m, 1'b0, "");
      run(32'h0020_2000, 32'h0070_5050);
      chkr(5'd5, m, 8'h0, "or_idx_a");
      mem(32'hc, b, 1'b1, "store_idx_a");
      st = (st & 32'h61) | {28'h0, m[31], m == 32'h0, 2'b00};
      flags(st, "flags_idx_a");
      // float pop into r9 is refused and nothing moves
      run(32'h0, 32'h92);
      flags(st | 32'h100, "illegal");
      // register second source refused while the option is off
      wr(stack_unit_pkg::OFS_CTRL, 32'h1);
      run(32'h0031_0035, 32'h0070_6060);
      flags(st | 32'h100, "src2_reg_off");
      chkr(5'd20, 32'h3, 8'h0, "sp_kept");
      results();
   end
endmodule : stack_and_parallel_or_store_tb
`default_nettype wire
